// [bench/scg_asserts.sv]
`timescale 1ns/1ns
`include "scg_defs.svh"
// link watcher: reset and strap holds, boot refusal, ready handshake
module scg_asserts #(
  parameter int         RST_CYC   = 4,
  parameter int         STRAP_CYC = 20,
  parameter int         BOOT_CYC  = 30,
  parameter int         LOCK_CYC  = 4,
  parameter logic [7:0] DEVICE_ID = 8'h5a  // arbitrary value
) (
  // clock and resets
  input wire logic       i_clock,
  input wire logic       i_rst_b,
  input wire logic       rst_b,
  // straps
  input wire logic       cs_strap,
  input wire logic       so_strap,
  input wire logic [2:0] cfg_sel,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       nack
);
  logic [9:0] up_reg;
  logic [9:0] low_reg;
  logic [9:0] done_reg;
  logic       seen_reg;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  // saturating counters so long runs never wrap into a false antecedent
  always_ff @(posedge i_clock) begin
    up_reg <= !rst_b ? 10'h000 : up_reg + {9'h000, up_reg != 10'h3ff};
  end
  always_ff @(posedge i_clock) begin
    // counted only once the bench reset is gone, so the unknown link reset
    // before the first edge cannot poison the count
    if (rst_b || !i_rst_b) begin
      low_reg <= 10'h000;
    end else begin
      low_reg <= low_reg + {9'h000, low_reg != 10'h3ff};
    end
  end
  // setup-done seen, and cycles since
  always_ff @(posedge i_clock) begin
    seen_reg <= rst_b && (seen_reg || (wr && addr == `SCG_OFF_CLK_DONE && wdata[0]));
  end
  always_ff @(posedge i_clock) begin
    done_reg <= !seen_reg ? 10'h000 : done_reg + {9'h000, done_reg != 10'h3ff};
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_one_strobe: assert property (!(wr && rd))
    else $error("read and write strobes together");
  a_idle_rdata: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero without a read");
  a_reset_hold: assert property ($rose(rst_b) |-> low_reg >= RST_CYC)
    else $error("link reset released too early");
  a_strap_hold: assert property (rst_b && up_reg < STRAP_CYC |=> $stable({cs_strap, so_strap, cfg_sel}))
    else $error("straps moved inside hold window");
  a_gated_strobe: assert property (rst_b && up_reg < STRAP_CYC |-> !wr && !rd)
    else $error("strobe inside strap window");
  a_boot_zero: assert property (rd && up_reg < BOOT_CYC - 2 |=> rdata == 8'h00)
    else $error("booting read not zero");
  a_boot_nack: assert property (rd && !cs_strap && up_reg < BOOT_CYC - 2 |=> nack)
    else $error("booting i2c read not refused");
  a_spi_no_nack: assert property (rd && cs_strap |=> !nack)
    else $error("nack in spi mode");
  a_id_ready: assert property (rd && addr == `SCG_OFF_ID && up_reg > BOOT_CYC + 2 |=> rdata == DEVICE_ID && !nack)
    else $error("identity wrong after boot");
  a_lock_wait: assert property (rd && addr == `SCG_OFF_CLK_STATUS && !seen_reg |=> !rdata[3])
    else $error("lock before setup done");
  a_ready_status: assert property (rd && addr == `SCG_OFF_CLK_STATUS && done_reg > LOCK_CYC + 2 |=> rdata == 8'h0b)
    else $error("status not ready after setup");
  a_info_ready: assert property (rd && addr == `SCG_OFF_INFO && done_reg > LOCK_CYC + 2 |=> rdata[7])
    else $error("info ready missing after setup");
  c_id: cover property (rd && addr == `SCG_OFF_ID ##1 rdata == DEVICE_ID);
  c_nack: cover property (rd ##1 nack);
  c_ready: cover property (seen_reg && rd && addr == `SCG_OFF_CLK_STATUS);
endmodule

// [bench/scg_bench.sv]
`timescale 1ns/1ns
`include "scg_defs.svh"
// host end and device end joined by the link, driven from the software port
module scg_bench;
  localparam int         STRAP_CYC = 20;
  localparam int         BOOT_CYC  = 30;  // longer than strap window so refusal is seen
  localparam int         LOCK_CYC  = 4;
  localparam int         GPIO_CYC  = 8;
  localparam int         RST_CYC   = 4;
  localparam logic [7:0] DEV_ID    = 8'h5a;  // arbitrary value
  logic       i_clock;
  logic       i_rst_b;
  logic       want_spi;
  logic       addr_lsb;
  logic [2:0] cfg_sel;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       nack;
  logic       link_up;
  logic [3:0] gpio_in;
  logic [3:0] gpio_out;
  logic [3:0] gpio_oe;
  logic       use_xtal;
  logic       dbl_en;
  logic       spi_sel;
  logic [6:0] i2c_addr;
  logic [2:0] cfg_applied;
  logic [7:0] out_en;
  logic [7:0] out_stop;
  int         miscompares;
  int         n_compared;
  int         cycles = 0;
  scg_if link ();
  ////////////////////////////////////////////////////////////////////////////////
  scg_host #(.RST_CYC(RST_CYC), .STRAP_CYC(STRAP_CYC)) i_scg_host (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_want_spi(want_spi), .i_addr_lsb(addr_lsb),
    .i_cfg_sel(cfg_sel), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_nack(nack), .o_link_up(link_up), .link(link.host));
  scg_device #(.NGPIO(4), .STRAP_CYC(STRAP_CYC), .GPIO_CYC(GPIO_CYC), .BOOT_CYC(BOOT_CYC),
    .LOCK_CYC(LOCK_CYC), .HAS_STORED(1'b1), .DEVICE_ID(DEV_ID)) i_scg_device (
    .i_clock(i_clock), .link(link.device), .i_gpio(gpio_in), .o_gpio(gpio_out),
    .o_gpio_oe(gpio_oe), .o_use_xtal(use_xtal), .o_doubler_en(dbl_en), .o_spi_sel(spi_sel),
    .o_i2c_addr(i2c_addr), .o_cfg_applied(cfg_applied), .o_out_en(out_en),
    .o_out_stop(out_stop));
  scg_asserts #(.RST_CYC(RST_CYC), .STRAP_CYC(STRAP_CYC), .BOOT_CYC(BOOT_CYC),
    .LOCK_CYC(LOCK_CYC), .DEVICE_ID(DEV_ID)) i_scg_asserts (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .rst_b(link.rst_b), .cs_strap(link.cs_strap),
    .so_strap(link.so_strap), .cfg_sel(link.cfg_sel), .addr(link.addr), .wdata(link.wdata),
    .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .nack(link.nack));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // hang guard: ceiling well above two passes
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // write ends just past the taking edge so registered results have landed
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
    #1;
  endtask
  // read data and nack stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic n);
    @(posedge i_clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
    #1;
    d = rdata;
    n = nack;
  endtask
  task automatic report_and_stop();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic run_pass(input logic spi, input logic lsb, input logic [2:0] cfg);
    logic [7:0] d;
    logic       n;
    int         k;
    @(posedge i_clock);
    want_spi <= spi;
    addr_lsb <= lsb;
    cfg_sel  <= cfg;
    gpio_in  <= 4'b0101;
    i_rst_b  <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    k = 0;
    while (link_up !== 1'b1 && k < 200) begin
      @(posedge i_clock);
      k++;
    end
    rd_reg(`SCG_OFF_ID, d, n);
    chk("boot read", 8'h00, d);
    chk("boot nack", {7'h00, !spi}, {7'h00, n});
    k = 0;
    while (d !== DEV_ID && k < 40) begin
      rd_reg(`SCG_OFF_ID, d, n);
      k++;
    end
    chk("device id", DEV_ID, d);
    chk("spi select", {7'h00, spi}, {7'h00, spi_sel});
    chk("i2c address", {1'b0, `SCG_I2C_ADDR_HI, lsb}, {1'b0, i2c_addr});
    chk("stored config", {5'h00, cfg}, {5'h00, cfg_applied});
    chk("outputs off", 8'h00, out_en);
    rd_reg(`SCG_OFF_REF_CFG, d, n);
    chk("ref cfg reset", `SCG_RST_REF_CFG, d);
    for (int v = 0; v < 4; v++) begin
      wr_reg(`SCG_OFF_REF_CFG, 8'(v));
      chk("ref source", {6'h00, v[1:0]}, {6'h00, dbl_en, use_xtal});
    end
    wr_reg(`SCG_OFF_MAILBOX, 8'ha5);
    rd_reg(`SCG_OFF_MAILBOX, d, n);
    chk("early mailbox", 8'h00, d);
    rd_reg(`SCG_OFF_CLK_STATUS, d, n);
    chk("lock before setup", 8'h00, {7'h00, d[3]});
    wr_reg(`SCG_OFF_PLL_INT, 8'hfa);
    wr_reg(`SCG_OFF_PLL_POST, 8'h02);
    wr_reg(`SCG_OFF_TRIM, 8'h10);
    wr_reg(`SCG_OFF_CLK_DONE, 8'h01);
    repeat (LOCK_CYC + 2) @(posedge i_clock);
    rd_reg(`SCG_OFF_CLK_STATUS, d, n);
    chk("clock status", 8'h0b, d);
    rd_reg(`SCG_OFF_INFO, d, n);
    chk("info ready", 8'h80, d);
    wr_reg(`SCG_OFF_MAILBOX, 8'h3c);
    rd_reg(`SCG_OFF_MAILBOX, d, n);
    chk("ready mailbox", 8'h3c, d);
    // pin0 input, pin1 output, pin2 control, pin3 status
    wr_reg(`SCG_OFF_GPIO_MODE, 8'he4);
    wr_reg(`SCG_OFF_GPIO_SEL, 8'h33);
    wr_reg(`SCG_OFF_GPIO_OUT, 8'h02);
    repeat (2 * GPIO_CYC + 4) @(posedge i_clock);
    #1;
    chk("gpio enables", 8'h0a, {4'h0, gpio_oe});
    chk("gpio drive", 8'h0a, {4'h0, gpio_out & gpio_oe});
    chk("ctrl enable", 8'hff, out_en);
    chk("no stop", 8'h00, out_stop);
    rd_reg(`SCG_OFF_GPIO_IN, d, n);
    chk("gpio level high", 8'h01, {7'h00, d[0]});
    // align to a refresh: the output pin only flips on a tick, and the
    // control level must then hold past the synchroniser delay
    wr_reg(`SCG_OFF_GPIO_OUT, 8'h00);
    k = 0;
    while (gpio_out[1] !== 1'b0 && k < 4 * GPIO_CYC) begin
      @(posedge i_clock);
      #1;
      k++;
    end
    chk("tick seen", 8'h00, {7'h00, gpio_out[1]});
    @(posedge i_clock);
    gpio_in <= 4'b0000;
    repeat (5) @(posedge i_clock);
    #1;
    chk("slow refresh", 8'hff, out_en);
    repeat (2 * GPIO_CYC + 4) @(posedge i_clock);
    #1;
    chk("ctrl release", 8'h00, out_en);
    rd_reg(`SCG_OFF_GPIO_IN, d, n);
    chk("gpio level low", 8'h00, {7'h00, d[0]});
    // control select bit low turns the pin into a stop request
    wr_reg(`SCG_OFF_GPIO_SEL, 8'h31);
    @(posedge i_clock);
    gpio_in <= 4'b0100;
    repeat (2 * GPIO_CYC + 4) @(posedge i_clock);
    #1;
    chk("ctrl stop", 8'hff, out_stop);
    chk("stop leaves enable", 8'h00, out_en);
    $display("test pass spi=%0b done", spi);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rst_b     = 1'b0;
    want_spi    = 1'b0;
    addr_lsb    = 1'b0;
    cfg_sel     = 3'h0;
    addr        = 8'h00;
    wdata       = 8'h00;
    wr          = 1'b0;
    rd          = 1'b0;
    gpio_in     = 4'h0;
    miscompares = 0;
    n_compared  = 0;
    run_pass(1'b0, 1'b1, 3'h5);
    run_pass(1'b1, 1'b0, 3'h2);
    report_and_stop();
  end
endmodule

// [hdl/scg_defs.svh]
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH
// user-side register offsets (8-bit address space)
`define SCG_OFF_REF_CFG      8'h00
`define SCG_OFF_PLL_INT      8'h01
`define SCG_OFF_PLL_POST     8'h02
`define SCG_OFF_TRIM         8'h03
`define SCG_OFF_CLK_DONE     8'h04
`define SCG_OFF_CLK_STATUS   8'h05
`define SCG_OFF_INFO         8'h06
`define SCG_OFF_ID           8'h07
`define SCG_OFF_GPIO_MODE    8'h08
`define SCG_OFF_GPIO_OUT     8'h09
`define SCG_OFF_GPIO_IN      8'h0a
`define SCG_OFF_GPIO_SEL     8'h0b
`define SCG_OFF_MAILBOX      8'h0c
`define SCG_OFF_OUT_EN       8'h0d
`define SCG_OFF_STRAPS       8'h0e
// field positions
`define SCG_BIT_XTAL_EN      0
`define SCG_BIT_DOUBLER_EN   1
`define SCG_BIT_PLL_LOCK     3
`define SCG_BIT_INFO_READY   7
`define SCG_CLK_STATE_READY  2'h3
// reset values
`define SCG_RST_REF_CFG      8'h00
`define SCG_RST_OUT_EN       8'h00
`define SCG_I2C_ADDR_HI      6'h1c
// timing
`define SCG_CLK_HZ           100000000
`define SCG_STRAP_HOLD_MS    550
`define SCG_GPIO_PERIOD_MS   10
`define SCG_BOOT_US          100
`define SCG_RESET_HOLD_MS    2
`define SCG_LOCK_US          10
`endif

// [hdl/scg_device.sv]
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "scg_defs.svh"
//
// Function
// - xtal enable bit picks crystal or oscillator
// - doubler enable doubles pll reference
// - host programs dividers for 12 GHz
// - host loads trim when not 12 GHz
// - setup done gives lock, ready state, ready
// - host holds reset low at least 2 ms
// - reset restores defaults, outputs disabled
// - host holds straps 550 ms after reset
// - chip-select strap low selects i2c
// - serial-out strap sets i2c address lsb
// - config pins pick stored config if present
// - booting reads zero or nack, then id
// - host polls id, sets pll, then rest
// - mailbox writes dropped until lock and ready
// - each gpio has its own mode
// - input mode reflects pin in input register
// - output mode drives pin from output register
// - control mode pin drives selected function
// - status mode pin mirrors selected status
// - gpio refreshed only every period
module scg_device #(
  parameter int          NGPIO       = 4,
  parameter int          STRAP_CYC   = `SCG_STRAP_HOLD_MS * (`SCG_CLK_HZ / 1000),
  parameter int          GPIO_CYC    = `SCG_GPIO_PERIOD_MS * (`SCG_CLK_HZ / 1000),
  parameter int          BOOT_CYC    = `SCG_BOOT_US * (`SCG_CLK_HZ / 1000000),
  parameter int          LOCK_CYC    = `SCG_LOCK_US * (`SCG_CLK_HZ / 1000000),
  parameter logic        HAS_STORED  = 1'b0,
  parameter logic [7:0]  DEVICE_ID   = 8'h5a  // arbitrary value
) (
  // clock
  input  wire logic             i_clock,
  // link
  scg_if.device                 link,
  // general-purpose pins
  input  wire logic [NGPIO-1:0] i_gpio,
  output logic      [NGPIO-1:0] o_gpio,
  output logic      [NGPIO-1:0] o_gpio_oe,
  // block outputs
  output logic                  o_use_xtal,
  output logic                  o_doubler_en,
  output logic                  o_spi_sel,
  output logic      [6:0]       o_i2c_addr,
  output logic      [2:0]       o_cfg_applied,
  output logic      [7:0]       o_out_en,
  output logic      [7:0]       o_out_stop
);
  ////////////////////////////////////////////////////////////////////////////
  logic              rst_b;
  logic [1:0]        straps_s;
  logic [2:0]        cfg_sel_s;
  logic [NGPIO-1:0]  gpio_s;
  scg_pkg::scg_state_t state_reg;
  logic [31:0]       cnt_reg;
  logic [31:0]       strap_cnt_reg;
  logic [31:0]       gpio_cnt_reg;
  logic              gpio_tick;
  logic [7:0]        ref_cfg_reg, pll_int_reg, pll_post_reg, trim_reg;
  logic [7:0]        mailbox_reg, out_en_reg, gpio_out_reg, gpio_sel_reg;
  logic [2*NGPIO-1:0] gpio_mode_reg;
  logic [NGPIO-1:0]  gpio_in_reg;
  logic [NGPIO-1:0]  ctrl_lvl_reg;
  logic              lock_reg;
  logic              ready;
  logic [7:0]        clk_status;
  logic [7:0]        info;
  logic [7:0]        rd_mux;

  assign rst_b = link.rst_b;

  // strap, config and gpio pins cross through two flops
  scg_sync #(.WIDTH(2)) u_sync_strap (
    .i_clock (i_clock),
    .i_async ({link.cs_strap, link.so_strap}),
    .o_sync  (straps_s)
  );
  scg_sync #(.WIDTH(3)) u_sync_cfg (
    .i_clock (i_clock),
    .i_async (link.cfg_sel),
    .o_sync  (cfg_sel_s)
  );
  scg_sync #(.WIDTH(NGPIO)) u_sync_gpio (
    .i_clock (i_clock),
    .i_async (i_gpio),
    .o_sync  (gpio_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // strap capture at the end of the hold window, never at reset itself
  always_ff @(posedge i_clock) begin
    if (!rst_b) begin
      strap_cnt_reg <= 32'h0;
      o_spi_sel     <= 1'b0;
      o_i2c_addr    <= 7'h00;
      o_cfg_applied <= 3'h0;
    end else if (strap_cnt_reg < 32'(STRAP_CYC)) begin
      strap_cnt_reg <= strap_cnt_reg + 32'h1;
      if (strap_cnt_reg == 32'(STRAP_CYC - 1)) begin
        o_spi_sel     <= straps_s[1];
        o_i2c_addr    <= {`SCG_I2C_ADDR_HI, straps_s[0]};
        o_cfg_applied <= HAS_STORED ? cfg_sel_s : 3'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot and pll state machine
  always_ff @(posedge i_clock) begin
    if (!rst_b) begin
      state_reg <= scg_pkg::SCG_BOOTING;
      cnt_reg   <= 32'h0;
      lock_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        scg_pkg::SCG_BOOTING: begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg == 32'(BOOT_CYC - 1)) begin
            state_reg <= scg_pkg::SCG_WAIT_CFG;
          end
        end
        scg_pkg::SCG_WAIT_CFG: begin
          cnt_reg <= 32'h0;
          if (link.wr && link.addr == `SCG_OFF_CLK_DONE && link.wdata[0]) begin
            state_reg <= scg_pkg::SCG_LOCKING;
          end
        end
        scg_pkg::SCG_LOCKING: begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg == 32'(LOCK_CYC - 1)) begin
            state_reg <= scg_pkg::SCG_READY;
            lock_reg  <= 1'b1;
          end
        end
        scg_pkg::SCG_READY: begin
          lock_reg <= 1'b1;
        end
      endcase
    end
  end

  assign ready = (state_reg == scg_pkg::SCG_READY);
  // lock shown as 1 = locked, the polarity the mailbox gate uses
  assign clk_status = {4'h0, lock_reg, 1'b0, ready ? `SCG_CLK_STATE_READY : 2'h0};
  assign info       = {ready, 7'h00};

  ////////////////////////////////////////////////////////////////////////////
  // writable registers; reset puts defaults back and disables outputs
  always_ff @(posedge i_clock) begin
    if (!rst_b) begin
      ref_cfg_reg   <= `SCG_RST_REF_CFG;
      pll_int_reg   <= 8'h00;
      pll_post_reg  <= 8'h00;
      trim_reg      <= 8'h00;
      mailbox_reg   <= 8'h00;
      out_en_reg    <= `SCG_RST_OUT_EN;
      gpio_out_reg  <= 8'h00;
      gpio_sel_reg  <= 8'h00;
      gpio_mode_reg <= '0;
    end else if (link.wr && state_reg != scg_pkg::SCG_BOOTING) begin
      // writes during boot are not accepted, matching the refused reads
      case (link.addr)
        `SCG_OFF_REF_CFG:   ref_cfg_reg   <= link.wdata;
        `SCG_OFF_PLL_INT:   pll_int_reg   <= link.wdata;
        `SCG_OFF_PLL_POST:  pll_post_reg  <= link.wdata;
        `SCG_OFF_TRIM:      trim_reg      <= link.wdata;
        `SCG_OFF_OUT_EN:    out_en_reg    <= link.wdata;
        `SCG_OFF_GPIO_OUT:  gpio_out_reg  <= link.wdata;
        `SCG_OFF_GPIO_SEL:  gpio_sel_reg  <= link.wdata;
        `SCG_OFF_GPIO_MODE: gpio_mode_reg <= link.wdata[2*NGPIO-1:0];
        `SCG_OFF_MAILBOX: begin
          if (lock_reg && ready) begin
            mailbox_reg <= link.wdata;
          end
        end
        default: ;
      endcase
    end
  end

  assign o_use_xtal   = ref_cfg_reg[`SCG_BIT_XTAL_EN];
  assign o_doubler_en = ref_cfg_reg[`SCG_BIT_DOUBLER_EN];

  ////////////////////////////////////////////////////////////////////////////
  // slow gpio refresh tick
  always_ff @(posedge i_clock) begin
    if (!rst_b || gpio_tick) begin
      gpio_cnt_reg <= 32'h0;
    end else begin
      gpio_cnt_reg <= gpio_cnt_reg + 32'h1;
    end
  end
  assign gpio_tick = (gpio_cnt_reg == 32'(GPIO_CYC - 1));

  // each pin sampled and driven only on the tick, by its own mode
  for (genvar g = 0; g < NGPIO; g++) begin : g_gpio
    always_ff @(posedge i_clock) begin
      if (!rst_b) begin
        gpio_in_reg[g]  <= 1'b0;
        ctrl_lvl_reg[g] <= 1'b0;
        o_gpio[g]       <= 1'b0;
        o_gpio_oe[g]    <= 1'b0;
      end else if (gpio_tick) begin
        unique case (scg_pkg::scg_mode_decode(gpio_mode_reg[2*g +: 2]))
          scg_pkg::SCG_GPIO_INPUT: begin
            gpio_in_reg[g] <= gpio_s[g];
            o_gpio_oe[g]   <= 1'b0;
          end
          scg_pkg::SCG_GPIO_OUTPUT: begin
            o_gpio[g]    <= gpio_out_reg[g];
            o_gpio_oe[g] <= 1'b1;
          end
          scg_pkg::SCG_GPIO_CTRL: begin
            ctrl_lvl_reg[g] <= gpio_s[g];
            o_gpio_oe[g]    <= 1'b0;
          end
          scg_pkg::SCG_GPIO_STATUS: begin
            // select nibble picks lock or ready; two pins share a nibble
            o_gpio[g]    <= gpio_sel_reg[4*(g%2)] ? lock_reg : ready;
            o_gpio_oe[g] <= 1'b1;
          end
        endcase
      end
    end
  end

  // control pins: select bit high = enable all outputs, low = stop all
  always_comb begin
    o_out_en   = out_en_reg;
    o_out_stop = 8'h00;
    for (int g = 0; g < NGPIO; g++) begin
      if (scg_pkg::scg_mode_decode(gpio_mode_reg[2*g +: 2]) == scg_pkg::SCG_GPIO_CTRL) begin
        if (gpio_sel_reg[4*(g%2)+1] && ctrl_lvl_reg[g]) begin
          o_out_en = 8'hff;
        end
        if (!gpio_sel_reg[4*(g%2)+1] && ctrl_lvl_reg[g]) begin
          o_out_stop = 8'hff;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; booting reads zero and refuses i2c
  always_comb begin
    case (link.addr)
      `SCG_OFF_REF_CFG:    rd_mux = ref_cfg_reg;
      `SCG_OFF_PLL_INT:    rd_mux = pll_int_reg;
      `SCG_OFF_PLL_POST:   rd_mux = pll_post_reg;
      `SCG_OFF_TRIM:       rd_mux = trim_reg;
      `SCG_OFF_CLK_STATUS: rd_mux = clk_status;
      `SCG_OFF_INFO:       rd_mux = info;
      `SCG_OFF_ID:         rd_mux = DEVICE_ID;
      `SCG_OFF_GPIO_MODE:  rd_mux = 8'(gpio_mode_reg);
      `SCG_OFF_GPIO_OUT:   rd_mux = gpio_out_reg;
      `SCG_OFF_GPIO_IN:    rd_mux = 8'(gpio_in_reg);
      `SCG_OFF_GPIO_SEL:   rd_mux = gpio_sel_reg;
      `SCG_OFF_MAILBOX:    rd_mux = mailbox_reg;
      `SCG_OFF_OUT_EN:     rd_mux = out_en_reg;
      `SCG_OFF_STRAPS:     rd_mux = {o_cfg_applied, o_spi_sel, o_i2c_addr[3:0]};
      default:             rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!rst_b) begin
      link.rdata <= 8'h00;
      link.nack  <= 1'b0;
    end else begin
      link.rdata <= (link.rd && state_reg != scg_pkg::SCG_BOOTING) ? rd_mux : 8'h00;
      link.nack  <= (link.rd || link.wr) && !o_spi_sel &&
                    state_reg == scg_pkg::SCG_BOOTING;
    end
  end
endmodule

// [hdl/scg_host.sv]
`timescale 1ns/1ns
`include "scg_defs.svh"
// host end: drives reset and straps, forwards software strobes to the link
module scg_host #(
  parameter int RST_CYC   = `SCG_RESET_HOLD_MS * (`SCG_CLK_HZ / 1000),
  parameter int STRAP_CYC = `SCG_STRAP_HOLD_MS * (`SCG_CLK_HZ / 1000)
) (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  // strap choices
  input  wire logic       i_want_spi,
  input  wire logic       i_addr_lsb,
  input  wire logic [2:0] i_cfg_sel,
  // software port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_nack,
  output logic            o_link_up,
  // link
  scg_if.host             link
);
  logic [31:0] cnt_reg;
  logic        in_rst_reg;
  logic        hold_reg;

  ////////////////////////////////////////////////////////////////////////////
  // reset pulse then strap hold window
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      cnt_reg    <= 32'h0;
      in_rst_reg <= 1'b1;
      hold_reg   <= 1'b1;
    end else if (in_rst_reg) begin
      cnt_reg <= cnt_reg + 32'h1;
      if (cnt_reg == 32'(RST_CYC - 1)) begin
        in_rst_reg <= 1'b0;
        cnt_reg    <= 32'h0;
      end
    end else if (hold_reg) begin
      cnt_reg <= cnt_reg + 32'h1;
      if (cnt_reg == 32'(STRAP_CYC)) begin
        hold_reg <= 1'b0;
      end
    end
  end

  assign link.rst_b    = !in_rst_reg;
  assign link.cs_strap = i_want_spi;
  assign link.so_strap = i_addr_lsb;
  assign link.cfg_sel  = i_cfg_sel;
  assign o_link_up     = !in_rst_reg && !hold_reg;
  // strobes pass only once the straps are released; software keeps
  // the id-poll, pll, rest order itself
  assign link.addr  = i_addr;
  assign link.wdata = i_wdata;
  assign link.wr    = i_wr && o_link_up;
  assign link.rd    = i_rd && o_link_up;
  assign o_rdata    = link.rdata;
  assign o_nack     = link.nack;
endmodule

// [hdl/scg_if.sv]
`timescale 1ns/1ns
// host-to-device link: reset, straps, and an 8-bit register port
interface scg_if;
  logic       rst_b;
  logic       cs_strap;
  logic       so_strap;
  logic [2:0] cfg_sel;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       nack;
  modport device (input rst_b, cs_strap, so_strap, cfg_sel, addr, wdata, wr, rd,
                  output rdata, nack);
  modport host   (output rst_b, cs_strap, so_strap, cfg_sel, addr, wdata, wr, rd,
                  input rdata, nack);
endinterface

// [hdl/scg_pkg.sv]
package scg_pkg;
  typedef enum logic [3:0] {
    SCG_GPIO_INPUT  = 4'h1,
    SCG_GPIO_OUTPUT = 4'h2,
    SCG_GPIO_CTRL   = 4'h4,
    SCG_GPIO_STATUS = 4'h8
  } scg_gpio_mode_t;
  typedef enum logic [3:0] {
    SCG_BOOTING  = 4'h1,
    SCG_WAIT_CFG = 4'h2,
    SCG_LOCKING  = 4'h4,
    SCG_READY    = 4'h8
  } scg_state_t;
  // 2-bit mode code per pin in the mode register
  function automatic scg_gpio_mode_t scg_mode_decode(input logic [1:0] code);
    case (code)
      2'h0:    scg_mode_decode = SCG_GPIO_INPUT;
      2'h1:    scg_mode_decode = SCG_GPIO_OUTPUT;
      2'h2:    scg_mode_decode = SCG_GPIO_CTRL;
      default: scg_mode_decode = SCG_GPIO_STATUS;
    endcase
  endfunction
endpackage

// [hdl/scg_sync.sv]
`timescale 1ns/1ns
// two-flop synchroniser for pin levels
module scg_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  // no reset: these only filter the pins
  always_ff @(posedge i_clock) begin
    meta_reg <= i_async;
    o_sync   <= meta_reg;
  end
endmodule
